// [src/bse_exec.sv]
// branch and subroutine-call execution unit with an avalon-mm register port
//
// Operation
// - increment loop branch adds one, branches when the new value is non-zero.
// - decrement loop branch subtracts one, branches when the new value is non-zero.
// - register test branch leaves the register, branches when it is non-zero.
// - untaken branch continues after the second or third instruction byte.
// - indexed branch is unconditional, always indexes with register three.
// - indexed forms add the index after the indirect pointer is fetched.
// - page-zero call displacement is signed -64..+63, based at address zero.
// - direct page-zero call target is taken modulo 8192.
// - direct page-zero call forces page bits 14 and 13 to zero.
// - page-zero call bumps stack pointer, pushes return address, then jumps.
// - true call pushes and jumps only when selector matches condition code or is three.
// - untaken call leaves stack pointer and return stack alone.
// - true call with selector three always calls.
// - every form honours the indirect flag by fetching the target pointer.
// - every instruction here completes in nine clock periods.
// - false call pushes and jumps only when selector differs from condition code.
// - false relative call never decodes with selector three.
`timescale 1ns/1ps
`default_nettype none
`include "bse_defs.svh"

module bse_exec
  import bse_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             busy_o
);

  bse_state_t  state_reg;
  logic [3:0]  cnt_reg;
  logic [7:0]  byte1_reg;
  logic [7:0]  byte2_reg;
  logic [7:0]  byte3_reg;
  logic [14:0] iar_reg;
  logic [1:0]  cc_reg;
  logic [2:0]  sp_reg;
  logic [7:0]  gpr_reg [4];
  logic [14:0] ras_reg [`BSE_RAS_DEPTH];
  logic [14:0] ptr_mem [`BSE_PTR_DEPTH];
  logic [5:0]  ptr_addr_reg;
  logic [14:0] tgt_reg;
  logic        taken_reg;
  logic        pushed_reg;
  logic        illegal_reg;
  logic [31:0] rdata_next;
  logic        wr_ok;
  logic        rd_req;
  logic        commit;
  logic [14:0] ea_final;
  logic [2:0]  sp_next;
  logic [31:0] regs_flat;

  bse_dec_if dif ();

  bse_dec u_dec (
    .d (dif.dec)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flat
      assign regs_flat[8*gi +: 8] = gpr_reg[gi];
    end
  endgenerate

  // decoder sees the latched instruction and live machine state
  assign dif.byte1 = byte1_reg;
  assign dif.byte2 = byte2_reg;
  assign dif.byte3 = byte3_reg;
  assign dif.instr_addr_reg   = iar_reg;
  assign dif.cc    = cc_reg;
  assign dif.regs  = regs_flat;

  // ---------------- avalon slave ----------------
  // one wait cycle per access, so readdata can come from a flop
  assign wr_ok  = avs_write_i && !avs_waitrequest_o;
  assign rd_req = avs_read_i && avs_waitrequest_o;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (avs_address_i)
      `BSE_OFF_INSTR:    rdata_next = {8'h00, byte3_reg, byte2_reg, byte1_reg};
      `BSE_OFF_STATUS: begin
        rdata_next[`BSE_ST_BUSY]    = (state_reg == BSE_ST_EXEC);
        rdata_next[`BSE_ST_TAKEN]   = taken_reg;
        rdata_next[`BSE_ST_PUSHED]  = pushed_reg;
        rdata_next[`BSE_ST_ILLEGAL] = illegal_reg;
      end
      `BSE_OFF_IAR:      rdata_next = {17'h00000, iar_reg};
      `BSE_OFF_CC:       rdata_next = {30'h00000000, cc_reg};
      `BSE_OFF_SP:       rdata_next = {29'h00000000, sp_reg};
      `BSE_OFF_R0:       rdata_next = {24'h000000, gpr_reg[0]};
      `BSE_OFF_R1:       rdata_next = {24'h000000, gpr_reg[1]};
      `BSE_OFF_R2:       rdata_next = {24'h000000, gpr_reg[2]};
      `BSE_OFF_R3:       rdata_next = {24'h000000, gpr_reg[3]};
      `BSE_OFF_RAS_TOP:  rdata_next = {17'h00000, ras_reg[sp_reg]};
      `BSE_OFF_PTR_ADDR: rdata_next = {26'h0000000, ptr_addr_reg};
      `BSE_OFF_PTR_DATA: rdata_next = {17'h00000, ptr_mem[ptr_addr_reg]};
      default:           rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_req) begin
      avs_readdata_o <= rdata_next;
    end
  end

  // ---------------- sequencer ----------------
  assign commit = (state_reg == BSE_ST_EXEC) && (cnt_reg == `BSE_CNT_LAST);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg <= BSE_ST_IDLE;
      cnt_reg   <= 4'h0;
      busy_o    <= 1'b0;
    end else begin
      unique case (state_reg)
        BSE_ST_IDLE: begin
          if (wr_ok && avs_address_i == `BSE_OFF_INSTR) begin
            state_reg <= BSE_ST_EXEC;
            cnt_reg   <= 4'h0;
            busy_o    <= 1'b1;
          end
        end
        BSE_ST_EXEC: begin
          // fixed length whatever the outcome
          if (commit) begin
            state_reg <= BSE_ST_IDLE;
            busy_o    <= 1'b0;
          end else begin
            cnt_reg <= 4'(cnt_reg + 4'h1);
          end
        end
      endcase
    end
  end

  // instruction bytes are frozen while executing
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      byte1_reg <= 8'h00;
      byte2_reg <= 8'h00;
      byte3_reg <= 8'h00;
    end else if (wr_ok && avs_address_i == `BSE_OFF_INSTR && state_reg == BSE_ST_IDLE) begin
      byte1_reg <= avs_writedata_i[7:0];
      byte2_reg <= avs_writedata_i[15:8];
      byte3_reg <= avs_writedata_i[23:16];
    end
  end

  // indirect pointer fetched mid-instruction, index added afterwards
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tgt_reg <= 15'h0000;
    end else if (state_reg == BSE_ST_EXEC && cnt_reg == `BSE_CNT_IND) begin
      if (dif.indirect)
        tgt_reg <= ptr_mem[dif.ea_pre[`BSE_PTR_AW-1:0]];
      else
        tgt_reg <= dif.ea_pre;
    end
  end

  assign ea_final = dif.indexed ? 15'(tgt_reg + {7'h00, gpr_reg[`BSE_INDEX_REG]})
                                : tgt_reg;

  // the decoder is combinational on the frozen bytes; results are used at commit
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      iar_reg <= `BSE_IAR_RST;
    end else if (commit && dif.cls != BSE_CL_NONE) begin
      iar_reg <= dif.take ? ea_final : dif.seq;
    end else if (wr_ok && avs_address_i == `BSE_OFF_IAR && state_reg == BSE_ST_IDLE) begin
      iar_reg <= avs_writedata_i[14:0];
    end
  end

  // only software moves the condition code; execution never writes it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cc_reg <= `BSE_CC_RST;
    end else if (wr_ok && avs_address_i == `BSE_OFF_CC && state_reg == BSE_ST_IDLE) begin
      cc_reg <= avs_writedata_i[1:0];
    end
  end

  assign sp_next = 3'(sp_reg + 3'h1);

  // stack wraps silently at eight entries, as a real return stack would
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sp_reg <= `BSE_SP_RST;
    end else if (commit && dif.push) begin
      sp_reg <= sp_next;
    end else if (wr_ok && avs_address_i == `BSE_OFF_SP && state_reg == BSE_ST_IDLE) begin
      sp_reg <= avs_writedata_i[2:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (commit && dif.push) begin
      ras_reg[sp_next] <= dif.seq;
    end
  end

  generate
    for (gi = 0; gi < 4; gi++) begin : g_gpr
      always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
          gpr_reg[gi] <= 8'h00;
        end else if (commit && dif.reg_wr && byte1_reg[1:0] == 2'(gi)) begin
          gpr_reg[gi] <= dif.reg_new;
        end else if (wr_ok && avs_address_i == 6'(`BSE_OFF_R0 + 4 * gi) &&
                     state_reg == BSE_ST_IDLE) begin
          gpr_reg[gi] <= avs_writedata_i[7:0];
        end
      end
    end
  endgenerate

  // pointer memory is loaded by software; no reset, it is plain storage
  always_ff @(posedge mclk_i) begin
    if (wr_ok && avs_address_i == `BSE_OFF_PTR_DATA && state_reg == BSE_ST_IDLE) begin
      ptr_mem[ptr_addr_reg] <= avs_writedata_i[14:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ptr_addr_reg <= 6'h00;
    end else if (wr_ok && avs_address_i == `BSE_OFF_PTR_ADDR) begin
      ptr_addr_reg <= avs_writedata_i[5:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      taken_reg   <= 1'b0;
      pushed_reg  <= 1'b0;
      illegal_reg <= 1'b0;
    end else if (commit) begin
      taken_reg   <= dif.take;
      pushed_reg  <= dif.push;
      illegal_reg <= (dif.cls == BSE_CL_NONE);
    end
  end

endmodule

`default_nettype wire

// [src/bse_defs.svh]
// register offsets, field positions, reset values and timing counts for the branch unit
`ifndef BSE_DEFS_SVH
`define BSE_DEFS_SVH

// avalon byte offsets, one aligned 32-bit word each
`define BSE_OFF_INSTR    6'h00
`define BSE_OFF_STATUS   6'h04
`define BSE_OFF_IAR      6'h08
`define BSE_OFF_CC       6'h0c
`define BSE_OFF_SP       6'h10
`define BSE_OFF_R0       6'h14
`define BSE_OFF_R1       6'h18
`define BSE_OFF_R2       6'h1c
`define BSE_OFF_R3       6'h20
`define BSE_OFF_RAS_TOP  6'h24
`define BSE_OFF_PTR_ADDR 6'h28
`define BSE_OFF_PTR_DATA 6'h2c

// status bit positions
`define BSE_ST_BUSY      0
`define BSE_ST_TAKEN     1
`define BSE_ST_PUSHED    2
`define BSE_ST_ILLEGAL   3

// reset values
`define BSE_IAR_RST      15'h0000
`define BSE_SP_RST       3'h0
`define BSE_CC_RST       2'h0

// opcode fields (upper six bits of the first byte)
`define BSE_OP_INC_REL   6'h36
`define BSE_OP_INC_ABS   6'h37
`define BSE_OP_DEC_REL   6'h3e
`define BSE_OP_DEC_ABS   6'h3f
`define BSE_OP_TST_REL   6'h16
`define BSE_OP_TST_ABS   6'h17
`define BSE_OP_IDX_ABS   6'h27
`define BSE_OP_TCL_REL   6'h0e
`define BSE_OP_TCL_ABS   6'h0f
`define BSE_OP_FCL_REL   6'h2e
`define BSE_SEL_ALWAYS   2'h3
`define BSE_INDEX_REG    2'h3

// execution time: 3 processor cycles of 3 clock periods each
`define BSE_EXEC_CYCLES  9
`define BSE_CNT_LAST     4'h8
`define BSE_CNT_IND      4'h2

// pointer memory used for indirect fetches, and the return stack depth
`define BSE_PTR_DEPTH    64
`define BSE_PTR_AW       6
`define BSE_RAS_DEPTH    8

`endif

// [src/bse_pkg.sv]
// types shared by the branch unit modules
package bse_pkg;

  typedef enum logic [2:0] {
    BSE_CL_NONE  = 3'b000,
    BSE_CL_INC   = 3'b001,
    BSE_CL_DEC   = 3'b010,
    BSE_CL_TST   = 3'b011,
    BSE_CL_IDX   = 3'b100,
    BSE_CL_ZCALL = 3'b101,
    BSE_CL_TCALL = 3'b110,
    BSE_CL_FCALL = 3'b111
  } bse_class_t;

  typedef enum logic [0:0] {
    BSE_ST_IDLE = 1'b0,
    BSE_ST_EXEC = 1'b1
  } bse_state_t;

endpackage

// [src/bse_dec_if.sv]
// carrier between the execution sequencer and the decode/address unit
`timescale 1ns/1ps
`default_nettype none

interface bse_dec_if;
  import bse_pkg::*;
  logic [7:0]  byte1;
  logic [7:0]  byte2;
  logic [7:0]  byte3;
  logic [14:0] instr_addr_reg;
  logic [1:0]  cc;
  logic [31:0] regs;
  bse_class_t  cls;
  logic        take;
  logic        push;
  logic        indirect;
  logic        indexed;
  logic        reg_wr;
  logic [7:0]  reg_new;
  logic [14:0] ea_pre;
  logic [14:0] seq;

  modport seqr (output byte1, byte2, byte3, instr_addr_reg, cc, regs,
                input  cls, take, push, indirect, indexed, reg_wr, reg_new, ea_pre, seq);
  modport dec  (input  byte1, byte2, byte3, instr_addr_reg, cc, regs,
                output cls, take, push, indirect, indexed, reg_wr, reg_new, ea_pre, seq);
endinterface

`default_nettype wire

// [src/bse_dec.sv]
// decode, condition test and effective-address pre-calculation
`timescale 1ns/1ps
`default_nettype none
`include "bse_defs.svh"

module bse_dec
  import bse_pkg::*;
(
  bse_dec_if.dec d
);

  logic [5:0]  op;
  logic [1:0]  sel;
  logic        is_abs;
  logic [7:0]  rval;
  logic [12:0] disp;
  logic [14:0] len;

  assign op   = d.byte1[7:2];
  assign sel  = d.byte1[1:0];
  assign rval = d.regs[8*sel +: 8];
  assign disp = {{6{d.byte2[6]}}, d.byte2[6:0]};

  always_comb begin
    d.cls  = BSE_CL_NONE;
    is_abs = 1'b0;
    unique case (op)
      `BSE_OP_INC_REL: d.cls = BSE_CL_INC;
      `BSE_OP_INC_ABS: begin d.cls = BSE_CL_INC; is_abs = 1'b1; end
      `BSE_OP_DEC_REL: d.cls = BSE_CL_DEC;
      `BSE_OP_DEC_ABS: begin d.cls = BSE_CL_DEC; is_abs = 1'b1; end
      `BSE_OP_TST_REL: d.cls = BSE_CL_TST;
      `BSE_OP_TST_ABS: begin d.cls = BSE_CL_TST; is_abs = 1'b1; end
      `BSE_OP_TCL_REL: d.cls = BSE_CL_TCALL;
      `BSE_OP_TCL_ABS: begin d.cls = BSE_CL_TCALL; is_abs = 1'b1; end
      `BSE_OP_IDX_ABS: begin
        // only the all-ones selector is the indexed branch here
        if (sel == `BSE_INDEX_REG) begin
          d.cls  = BSE_CL_IDX;
          is_abs = 1'b1;
        end
      end
      `BSE_OP_FCL_REL: begin
        // selector three is the page-zero call, never the false call
        if (sel == `BSE_SEL_ALWAYS) d.cls = BSE_CL_ZCALL;
        else d.cls = BSE_CL_FCALL;
      end
      default: d.cls = BSE_CL_NONE;
    endcase
  end

  // return/fall-through address stays inside the current page
  assign len   = is_abs ? 15'h0003 : 15'h0002;
  assign d.seq = {d.instr_addr_reg[14:13], 13'(d.instr_addr_reg[12:0] + len[12:0])};

  always_comb begin
    if (d.cls == BSE_CL_ZCALL)
      d.ea_pre = {2'b00, disp};
    else if (is_abs)
      d.ea_pre = {d.byte2[6:0], d.byte3};
    else
      d.ea_pre = {d.seq[14:13], 13'(d.seq[12:0] + disp)};
  end

  assign d.indirect = d.byte2[7];
  assign d.indexed  = (d.cls == BSE_CL_IDX);

  always_comb begin
    d.reg_wr  = 1'b0;
    d.reg_new = rval;
    d.take    = 1'b0;
    unique case (d.cls)
      BSE_CL_NONE: d.take = 1'b0;
      BSE_CL_INC: begin
        d.reg_wr  = 1'b1;
        d.reg_new = 8'(rval + 8'h01);
        d.take    = (d.reg_new != 8'h00);
      end
      BSE_CL_DEC: begin
        d.reg_wr  = 1'b1;
        d.reg_new = 8'(rval - 8'h01);
        d.take    = (d.reg_new != 8'h00);
      end
      BSE_CL_TST:   d.take = (rval != 8'h00);
      BSE_CL_IDX:   d.take = 1'b1;
      BSE_CL_ZCALL: d.take = 1'b1;
      BSE_CL_TCALL: d.take = (sel == `BSE_SEL_ALWAYS) || (sel == d.cc);
      BSE_CL_FCALL: d.take = (sel != d.cc);
    endcase
  end

  assign d.push = d.take && (d.cls == BSE_CL_ZCALL || d.cls == BSE_CL_TCALL ||
                             d.cls == BSE_CL_FCALL);

endmodule

`default_nettype wire

// [bench/bse_exec_props.sv]
// concurrent checks on the branch unit register port and execution timing
`timescale 1ns/1ps
`default_nettype none

module bse_exec_props (
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        busy_o
);
  logic [1:0] cc_seen_reg;
  wire        acc_w    = avs_write_i && !avs_waitrequest_o;
  wire        instr_go = acc_w && !busy_o && avs_address_i == 6'h00;
  wire        rd_take  = avs_read_i && avs_waitrequest_o;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // only software may move the condition code, and only while idle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)
      cc_seen_reg <= 2'h0;
    else if (acc_w && !busy_o && avs_address_i == 6'h0c)
      cc_seen_reg <= avs_writedata_i[1:0];
  end

  busy_len_a: assert property ($rose(busy_o) |=> busy_o[*8] ##1 !busy_o)
    else $error("busy did not last nine cycles");
  busy_start_a: assert property (instr_go |=> busy_o)
    else $error("instruction write did not start execution");
  busy_cause_a: assert property ($rose(busy_o) |-> $past(instr_go))
    else $error("execution started without an instruction write");
  cc_kept_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 6'h0c
    |-> avs_readdata_o[1:0] == cc_seen_reg)
    else $error("condition code changed by execution");
  status_busy_a: assert property (rd_take && avs_address_i == 6'h04
    |=> avs_readdata_o[0] == $past(busy_o))
    else $error("status busy bit disagrees with busy output");
  unmapped_zero_a: assert property (rd_take && avs_address_i[5:4] == 2'b11
    |=> avs_readdata_o == 32'h0)
    else $error("unmapped address read not zero");
  wait_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("request not answered after one wait cycle");
  wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  wait_idle_a: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o
    |=> avs_waitrequest_o)
    else $error("answer without a request");
  rdata_hold_a: assert property (!rd_take |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");

  cover property ($rose(busy_o));
  cover property (avs_read_i && !avs_waitrequest_o && avs_address_i == 6'h04
    && avs_readdata_o[2]);
  cover property (rd_take && avs_address_i[5:4] == 2'b11);
endmodule

bind bse_exec bse_exec_props bse_exec_props_inst (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o));

`default_nettype wire

// [bench/branch_subroutine_exec_tb.sv]
// self-checking bench for the branch unit: register port, branches and calls
`timescale 1ns/1ps
`default_nettype none

module branch_subroutine_exec_tb;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [5:0]  avs_address_i = 6'h00;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        busy_o;
  int          miscompares = 0;
  int          n_checks = 0;
  integer      seed = 50;
  logic [14:0] ptrm [64];
  logic [7:0]  rg [4];
  logic [14:0] instr_addr_reg = 15'h0;
  logic [1:0]  cc = 2'h0;
  logic [2:0]  sp = 3'h0;
  logic [31:0] rd;
  logic [31:0] u;
  logic [5:0]  ops [10] = '{6'h36, 6'h37, 6'h3e, 6'h3f, 6'h16, 6'h17, 6'h27, 6'h0e, 6'h0f, 6'h2e};

  always #4 mclk_i = ~mclk_i;

  bse_exec bse_exec_inst (
    .mclk_i            (mclk_i),
    .sys_rst_i         (sys_rst_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .busy_o            (busy_o)
  );

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  // request held until waitrequest is sampled low, then one idle gap cycle
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge mclk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 40);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
    if (k >= 40) begin
      miscompares++;
      end_sim();
    end
  endtask

  task automatic rdchk(input string w, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(w, e, rd);
  endtask

  task automatic run_one(input logic [7:0] b1, b2, b3);
    logic [5:0]  op;
    logic [1:0]  f;
    logic [14:0] ret, a;
    logic [7:0]  nr;
    logic        tk, ps, ill;
    op = b1[7:2];
    f = b1[1:0];
    bus(1'b1, 6'h08, {17'h0, instr_addr_reg});
    bus(1'b1, 6'h0c, {30'h0, cc});
    bus(1'b1, 6'h10, {29'h0, sp});
    for (int i = 0; i < 4; i++) bus(1'b1, 6'h14 + 6'(4 * i), {24'h0, rg[i]});
    bus(1'b1, 6'h00, {8'h0, b3, b2, b1});
    // rd still holds an older read here, so force at least one status poll
    rd = 32'h0000_0001;
    for (int n = 0; n < 20 && rd[0] !== 1'b0; n++) bus(1'b0, 6'h04, 32'h0);
    if (rd[0] !== 1'b0) begin
      miscompares++;
      end_sim();
    end
    // expected outcome worked out from the instruction bytes and the shadow state
    ret = {instr_addr_reg[14:13], instr_addr_reg[12:0] + (op[0] ? 13'd3 : 13'd2)};
    a = op[0] ? {b2[6:0], b3} : {instr_addr_reg[14:13], ret[12:0] + {{6{b2[6]}}, b2[6:0]}};
    if (b1 == 8'hbb) a = {2'b00, {6{b2[6]}}, b2[6:0]};
    if (b2[7]) a = ptrm[a[5:0]];
    if (op == 6'h27) a = a + {7'h0, rg[3]};
    nr = rg[f];
    tk = 1'b0;
    ill = 1'b0;
    case (op)
      6'h36, 6'h37: begin nr = rg[f] + 8'h01; tk = nr != 8'h0; end
      6'h3e, 6'h3f: begin nr = rg[f] - 8'h01; tk = nr != 8'h0; end
      6'h16, 6'h17: tk = rg[f] != 8'h0;
      6'h27: begin tk = f == 2'h3; ill = !tk; end
      6'h0e, 6'h0f: tk = f == 2'h3 || f == cc;
      6'h2e: tk = f == 2'h3 || f != cc;
      default: ill = 1'b1;
    endcase
    ps = tk && (op == 6'h0e || op == 6'h0f || op == 6'h2e);
    chk("status", {28'h0, ill, ps, tk, 1'b0}, rd);
    if (!ill) begin
      rg[f] = nr;
      instr_addr_reg = tk ? a : ret;
    end
    if (ps) sp = sp + 3'h1;
    rdchk("iar", 6'h08, {17'h0, instr_addr_reg});
    rdchk("stack pointer", 6'h10, {29'h0, sp});
    rdchk("condition code", 6'h0c, {30'h0, cc});
    rdchk("register", 6'h14 + {2'b00, f, 2'b00}, {24'h0, rg[f]});
    if (ps) rdchk("return top", 6'h24, {17'h0, ret});
  endtask

  task automatic corner(input logic [7:0] b1, b2, b3, rv, input logic [1:0] c,
                        input logic [14:0] i);
    rg[b1[1:0]] = rv;
    cc = c;
    instr_addr_reg = i;
    run_one(b1, b2, b3);
  endtask

  initial begin
    for (int i = 0; i < 4; i++) rg[i] = 8'h00;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    for (int i = 0; i < 9; i++) rdchk("reset value", 6'(4 * i), 32'h0);
    rdchk("unmapped", 6'h30, 32'h0);
    $display("test reset done");
    // pointer memory is not reset, so every entry gets a known value first
    for (int i = 0; i < 64; i++) begin
      ptrm[i] = 15'($random(seed));
      bus(1'b1, 6'h28, 32'(i));
      bus(1'b1, 6'h2c, {17'h0, ptrm[i]});
    end
    $display("test pointer load done");
    sp = 3'h7;
    corner(8'hd9, 8'h05, 8'h00, 8'hff, 2'h0, 15'h1ffe);
    corner(8'hde, 8'h12, 8'h34, 8'h7f, 2'h1, 15'h2345);
    corner(8'hf8, 8'h7f, 8'h00, 8'h01, 2'h2, 15'h4100);
    corner(8'hff, 8'h81, 8'h05, 8'h00, 2'h3, 15'h0777);
    corner(8'h5a, 8'h10, 8'h00, 8'h00, 2'h0, 15'h7ffd);
    corner(8'h5d, 8'h7f, 8'hff, 8'h01, 2'h0, 15'h1000);
    corner(8'h9f, 8'h80, 8'h21, 8'h40, 2'h2, 15'h3000);
    corner(8'h9f, 8'h7f, 8'hf0, 8'h20, 2'h1, 15'h0100);
    corner(8'hbb, 8'h76, 8'h00, 8'h00, 2'h0, 15'h6abc);
    corner(8'hbb, 8'h3f, 8'h00, 8'h00, 2'h1, 15'h3ffe);
    corner(8'hbb, 8'h40, 8'h00, 8'h00, 2'h2, 15'h0000);
    corner(8'h3b, 8'h7c, 8'h00, 8'h00, 2'h1, 15'h0400);
    corner(8'h3e, 8'h12, 8'h00, 8'h00, 2'h1, 15'h0500);
    corner(8'h39, 8'h85, 8'h00, 8'h00, 2'h1, 15'h0600);
    corner(8'hb9, 8'h05, 8'h00, 8'h00, 2'h1, 15'h0700);
    corner(8'hb8, 8'h85, 8'h00, 8'h00, 2'h2, 15'h5f00);
    corner(8'h00, 8'h85, 8'h00, 8'h00, 2'h3, 15'h0800);
    $display("test corners done");
    // mid-run reset must clear the status flags left by the illegal corner
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    for (int i = 0; i < 9; i++) rdchk("reset value", 6'(4 * i), 32'h0);
    $display("test mid-run reset done");
    for (int n = 0; n < 40; n++) begin
      u = $random(seed);
      instr_addr_reg = u[14:0];
      cc = u[16:15];
      sp = u[19:17];
      for (int i = 0; i < 4; i++) rg[i] = 8'($random(seed));
      u = $random(seed);
      if (ops[u[7:0] % 10] == 6'h27) u[9:8] = 2'h3;
      if ({ops[u[7:0] % 10], u[9:8]} == 8'hbb) u[23] = 1'b0;
      run_one({ops[u[7:0] % 10], u[9:8]}, u[23:16], u[31:24]);
    end
    $display("test random done");
    end_sim();
  end
endmodule

`default_nettype wire
